//--- hdl/psd_pkg.sv
/*
  psd_pkg: register indices, field codes, reset values and bus widths
  shared by the power stage diagnostic register bank.
  Assumes byte addressing on the bus, one 32-bit word per register,
  so the byte address of a register is four times its index.
*/
package psd_pkg;

  // register indices
  localparam logic [4:0] IDX_GROUP_A   = 5'h01;
  localparam logic [4:0] IDX_GROUP_E   = 5'h02;
  localparam logic [4:0] IDX_GROUP_B   = 5'h05;
  localparam logic [4:0] IDX_BRIDGE1   = 5'h06;
  localparam logic [4:0] IDX_GROUP_C   = 5'h09;
  localparam logic [4:0] IDX_BRIDGE2   = 5'h0a;
  localparam logic [4:0] IDX_GROUP_D   = 5'h0d;
  localparam logic [4:0] IDX_STEP_CFG  = 5'h10;
  localparam logic [4:0] IDX_LB_CTRL   = 5'h11;
  localparam logic [4:0] IDX_IRQ_STAT  = 5'h12;
  localparam logic [4:0] IDX_IRQ_MASK  = 5'h13;

  // byte address bits that carry the index
  localparam int IDX_LSB = 2;
  localparam int IDX_W   = 5;

  // stage diagnosis codes
  localparam logic [1:0] CODE_SHORT_TO_GROUND  = 2'h0;
  localparam logic [1:0] CODE_OPEN_LOAD        = 2'h1;
  localparam logic [1:0] CODE_SHORT_TO_BATTERY = 2'h2;
  localparam logic [1:0] CODE_STAGE_OK         = 2'h3;

  // bridge diagnosis codes
  localparam logic [7:0] BR_SHORT_GND_OFF = 8'h01;
  localparam logic [7:0] BR_OPEN_LOAD_ON  = 8'h02;
  localparam logic [7:0] BR_OVERCURR_ON   = 8'h03;
  localparam logic [7:0] BR_OPEN_LOAD_OFF = 8'h04;
  localparam logic [7:0] BR_SHORT_BAT_OFF = 8'h05;
  localparam logic [7:0] BR_DETECT_RUN    = 8'h07;
  localparam logic [7:0] BR_OK            = 8'hff;

  // configuration fields and resets
  localparam int         CFG_BRIDGE_BIT   = 0;
  localparam logic [7:0] CFG_RESET        = 8'h01;
  localparam int         LB_S21_BIT       = 0;
  localparam int         LB_S25_BIT       = 1;
  localparam logic [1:0] LB_RESET         = 2'h0;
  localparam logic [3:0] GROUP_E_UPPER    = 4'hf;

  // interrupt status layout: one bit per diagnostic register except bridge two
  localparam int         IRQ_W            = 6;
  localparam int         IRQ_A            = 0;
  localparam int         IRQ_B            = 1;
  localparam int         IRQ_C            = 2;
  localparam int         IRQ_D            = 3;
  localparam int         IRQ_E            = 4;
  localparam int         IRQ_F            = 5;
  localparam logic [5:0] IRQ_RESET        = 6'h00;

  // stage count on the diagnosis input vector
  localparam int NUM_STAGES = 24;

endpackage

//--- hdl/psd_fault_latch.sv
/*
  psd_fault_latch: one sticky diagnosis field, cleared by a read.
  Assumes det is synchronous to clk and shows OK_CODE when healthy.
*/
`timescale 1ns/1ps
`default_nettype none

module psd_fault_latch #(
  parameter int             W       = 2,
  parameter logic [W-1:0]   OK_CODE = '1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] det,
  input  wire logic         clr,
  output logic [W-1:0]      held,
  output logic              hit
);

  typedef struct packed {
    logic [W-1:0] code;
  } psd_latch_t;

  psd_latch_t state;
  psd_latch_t next_state;

  initial begin
    if (W < 1) begin
      $error("psd_fault_latch: width must be at least one");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // a fresh fault wins over a clear in the same cycle, so nothing is lost
  always_comb begin
    next_state = state;
    if (det != OK_CODE) begin
      next_state.code = det;
    end else if (clr) begin
      next_state.code = OK_CODE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state.code <= OK_CODE;
    end else begin
      state <= next_state;
    end
  end

  assign held = state.code;
  assign hit  = (det != OK_CODE);

endmodule

`default_nettype wire

//--- hdl/psd_diag_regs.sv
/*
  psd_diag_regs: diagnostic register bank for the low-side and pre-driver
  stages and the stepper stage configuration, behind a classic Wishbone
  slave with 32-bit data. Assumes fault inputs and the watchdog alarm pin
  are synchronous to ref_clk; a stage input shows 2'b11 while healthy.
*/
// Functional notes
// - config bit 0 set makes stages 21 to 28 two full bridges; config resets to 0x01.
// - config bit 0 clear runs stages 21 to 24 as independent single stages.
// - stage fields code 00 ground short, 01 open load, 10 battery short, 11 healthy.
// - group a holds stages 4, 3, 2, 1 from the top bit pair down.
// - group b holds stages 8, 7, 6, 5 from the top bit pair down.
// - group c holds stage 14, stage 13, the watchdog alarm level, a zero bit and stage 9.
// - the watchdog alarm bit shows the live pin level and is never latched or cleared.
// - group d holds stages 18, 17, 16, 15 from the top bit pair down.
// - group e always reads ones in bits 7 to 4.
// - group e holds stage 20 in bits 3:2 and stage 19 in bits 1:0.
// - latched fault codes clear when their register is read.
// - in single mode the bridge one register holds stages 24, 23, 22, 21.
// - in bridge mode the bridge one register holds one 8-bit bridge code.
// - bridge codes are 01, 05, 04, 02, 03, 07 for the fault kinds and ff for healthy.
// - a low-battery enable for stage 21 or 25 forces stages 21 to 28 independent.
`timescale 1ns/1ps
`default_nettype none

module psd_diag_regs #(
  parameter int AW = 8
) (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  // wishbone classic slave
  input  wire logic                             wb_cyc_i,
  input  wire logic                             wb_stb_i,
  input  wire logic                             wb_we_i,
  input  wire logic [AW-1:0]                    wb_adr_i,
  input  wire logic [3:0]                       wb_sel_i,
  input  wire logic [31:0]                      wb_dat_i,
  output logic [31:0]                           wb_dat_o,
  output logic                                  wb_ack_o,
  // diagnosis from the stage monitors, stage n at bits 2n-1:2n-2
  input  wire logic [2*psd_pkg::NUM_STAGES-1:0] stageFaultCode,
  input  wire logic [7:0]                       bridgeOneFaultCode,
  input  wire logic [7:0]                       bridgeTwoFaultCode,
  input  wire logic                             watchdogAlarmPin,
  // stage configuration and interrupt
  output logic                                  bridgeModeActive,
  output logic                                  lowQuadSingle,
  output logic                                  highQuadSingle,
  output logic                                  irq
);

  initial begin
    if (AW < psd_pkg::IDX_LSB + psd_pkg::IDX_W) begin
      $error("psd_diag_regs: address too narrow for the register map");
    end
  end

  typedef struct packed {
    logic                     ack;
    logic [31:0]              rdata;
    logic [7:0]               stepCfg;
    logic [1:0]               lbCtrl;
    logic [psd_pkg::IRQ_W-1:0] irqStat;
    logic [psd_pkg::IRQ_W-1:0] irqMask;
    logic                     irq;
    logic                     bridgeOn;
    logic                     lowSingle;
    logic                     highSingle;
  } psd_state_t;

  psd_state_t state;
  psd_state_t next_state;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic                    reqNew;
  logic                    readNew;
  logic                    writeNew;
  logic [psd_pkg::IDX_W-1:0] regIdx;
  logic                    adrHigh;

  // a request is taken once, in the cycle before ack rises
  assign reqNew   = wb_cyc_i && wb_stb_i && !state.ack;
  assign readNew  = reqNew && !wb_we_i;
  assign writeNew = reqNew && wb_we_i;
  assign regIdx   = wb_adr_i[psd_pkg::IDX_LSB +: psd_pkg::IDX_W];

  generate
    if (AW > psd_pkg::IDX_LSB + psd_pkg::IDX_W) begin : g_high
      assign adrHigh = |wb_adr_i[AW-1:psd_pkg::IDX_LSB + psd_pkg::IDX_W];
    end else begin : g_nohigh
      assign adrHigh = 1'b0;
    end
  endgenerate

  // read strobes that clear the sticky fields; plain expressions, since a
  // function reading module signals would not wake a continuous assignment
  logic rdHit;
  logic rdA;
  logic rdB;
  logic rdC;
  logic rdD;
  logic rdE;
  logic rdF;
  logic rdIrq;

  assign rdHit = readNew && !adrHigh;
  assign rdA   = rdHit && (regIdx == psd_pkg::IDX_GROUP_A);
  assign rdB   = rdHit && (regIdx == psd_pkg::IDX_GROUP_B);
  assign rdC   = rdHit && (regIdx == psd_pkg::IDX_GROUP_C);
  assign rdD   = rdHit && (regIdx == psd_pkg::IDX_GROUP_D);
  assign rdE   = rdHit && (regIdx == psd_pkg::IDX_GROUP_E);
  assign rdF   = rdHit && (regIdx == psd_pkg::IDX_BRIDGE1);
  assign rdIrq = rdHit && (regIdx == psd_pkg::IDX_IRQ_STAT);

  ////////////////////////////////////////////////////////////////////////
  // per-stage sticky fields; stages 10 to 12 have no field here
  logic [1:0] stageHeld [1:psd_pkg::NUM_STAGES];
  logic       stageHit  [1:psd_pkg::NUM_STAGES];

  genvar n;
  generate
    for (n = 1; n <= psd_pkg::NUM_STAGES; n++) begin : g_stage
      if (n >= 10 && n <= 12) begin : g_none
        assign stageHeld[n] = psd_pkg::CODE_STAGE_OK;
        assign stageHit[n]  = 1'b0;
      end else begin : g_latch
        logic clrStage;
        // each stage clears with the register that shows it
        if (n <= 4) begin : g_a
          assign clrStage = rdA;
        end else if (n <= 8) begin : g_b
          assign clrStage = rdB;
        end else if (n <= 14) begin : g_c
          assign clrStage = rdC;
        end else if (n <= 18) begin : g_d
          assign clrStage = rdD;
        end else if (n <= 20) begin : g_e
          assign clrStage = rdE;
        end else begin : g_f
          // only a read in single mode shows, and so clears, these
          assign clrStage = rdF && !state.bridgeOn;
        end
        psd_fault_latch #(
          .W       (2),
          .OK_CODE (psd_pkg::CODE_STAGE_OK)
        ) u_latch (
          .clk  (ref_clk),
          .rst  (rst),
          .det  (stageFaultCode[2*(n-1) +: 2]),
          .clr  (clrStage),
          .held (stageHeld[n]),
          .hit  (stageHit[n])
        );
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // bridge one code, sticky until read in bridge mode
  logic [7:0] bridgeHeld;
  logic       bridgeHit;
  logic       bridgeClr;

  assign bridgeClr = rdF && state.bridgeOn;

  psd_fault_latch #(
    .W       (8),
    .OK_CODE (psd_pkg::BR_OK)
  ) u_bridge_one (
    .clk  (ref_clk),
    .rst  (rst),
    .det  (bridgeOneFaultCode),
    .clr  (bridgeClr),
    .held (bridgeHeld),
    .hit  (bridgeHit)
  );

  ////////////////////////////////////////////////////////////////////////
  // register images
  logic [7:0] imgA;
  logic [7:0] imgB;
  logic [7:0] imgC;
  logic [7:0] imgD;
  logic [7:0] imgE;
  logic [7:0] imgF;

  assign imgA = {stageHeld[4], stageHeld[3], stageHeld[2], stageHeld[1]};
  assign imgB = {stageHeld[8], stageHeld[7], stageHeld[6], stageHeld[5]};
  // alarm level is read straight from the pin, no latch in its path
  assign imgC = {stageHeld[14], stageHeld[13], watchdogAlarmPin, 1'b0,
                 stageHeld[9]};
  assign imgD = {stageHeld[18], stageHeld[17], stageHeld[16], stageHeld[15]};
  assign imgE = {psd_pkg::GROUP_E_UPPER, stageHeld[20], stageHeld[19]};
  // bridge mode swaps the per-stage fields for one bridge code
  assign imgF = state.bridgeOn ? bridgeHeld :
                {stageHeld[24], stageHeld[23], stageHeld[22], stageHeld[21]};

  // interrupt events, one per diagnostic register except bridge two
  logic [psd_pkg::IRQ_W-1:0] irqEvent;

  always_comb begin
    irqEvent = '0;
    irqEvent[psd_pkg::IRQ_A] = stageHit[1] || stageHit[2] || stageHit[3] || stageHit[4];
    irqEvent[psd_pkg::IRQ_B] = stageHit[5] || stageHit[6] || stageHit[7] || stageHit[8];
    irqEvent[psd_pkg::IRQ_C] = stageHit[9] || stageHit[13] || stageHit[14];
    irqEvent[psd_pkg::IRQ_D] = stageHit[15] || stageHit[16] || stageHit[17] || stageHit[18];
    irqEvent[psd_pkg::IRQ_E] = stageHit[19] || stageHit[20];
    irqEvent[psd_pkg::IRQ_F] = state.bridgeOn ? bridgeHit :
                               (stageHit[21] || stageHit[22] || stageHit[23] || stageHit[24]);
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses read zero and still get an ack
  logic [31:0] readValue;

  always_comb begin
    readValue = 32'h0000_0000;
    if (!adrHigh) begin
      unique case (regIdx)
        psd_pkg::IDX_GROUP_A:  readValue[7:0] = imgA;
        psd_pkg::IDX_GROUP_B:  readValue[7:0] = imgB;
        psd_pkg::IDX_GROUP_C:  readValue[7:0] = imgC;
        psd_pkg::IDX_GROUP_D:  readValue[7:0] = imgD;
        psd_pkg::IDX_GROUP_E:  readValue[7:0] = imgE;
        psd_pkg::IDX_BRIDGE1:  readValue[7:0] = imgF;
        psd_pkg::IDX_BRIDGE2:  readValue[7:0] = bridgeTwoFaultCode;
        psd_pkg::IDX_STEP_CFG: readValue[7:0] = state.stepCfg;
        psd_pkg::IDX_LB_CTRL:  readValue[1:0] = state.lbCtrl;
        psd_pkg::IDX_IRQ_STAT: readValue[psd_pkg::IRQ_W-1:0] = state.irqStat;
        psd_pkg::IDX_IRQ_MASK: readValue[psd_pkg::IRQ_W-1:0] = state.irqMask;
        default:               readValue = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: bus answer, writable registers, mode and interrupt
  always_comb begin
    next_state     = state;
    // ack lasts one cycle; the master releases before the next request
    next_state.ack = reqNew;
    if (readNew) begin
      next_state.rdata = readValue;
    end

    // writes need byte lane 0, where all the narrow registers sit
    if (writeNew && !adrHigh && wb_sel_i[0]) begin
      unique case (regIdx)
        psd_pkg::IDX_STEP_CFG: next_state.stepCfg = wb_dat_i[7:0];
        psd_pkg::IDX_LB_CTRL:  next_state.lbCtrl  = wb_dat_i[1:0];
        psd_pkg::IDX_IRQ_MASK: next_state.irqMask = wb_dat_i[psd_pkg::IRQ_W-1:0];
        default:               next_state.stepCfg = state.stepCfg;
      endcase
    end

    // status is read-to-clear; an event in the same cycle stays set
    if (rdIrq) begin
      next_state.irqStat = irqEvent;
    end else begin
      next_state.irqStat = state.irqStat | irqEvent;
    end
    next_state.irq = |(next_state.irqStat & next_state.irqMask);

    // low-battery enables override the bridge selection
    next_state.bridgeOn   = next_state.stepCfg[psd_pkg::CFG_BRIDGE_BIT] &&
                            !next_state.lbCtrl[psd_pkg::LB_S21_BIT] &&
                            !next_state.lbCtrl[psd_pkg::LB_S25_BIT];
    next_state.lowSingle  = !next_state.bridgeOn;
    next_state.highSingle = next_state.lbCtrl[psd_pkg::LB_S21_BIT] ||
                            next_state.lbCtrl[psd_pkg::LB_S25_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state.ack        <= 1'b0;
      state.rdata      <= 32'h0000_0000;
      state.stepCfg    <= psd_pkg::CFG_RESET;
      state.lbCtrl     <= psd_pkg::LB_RESET;
      state.irqStat    <= psd_pkg::IRQ_RESET;
      state.irqMask    <= psd_pkg::IRQ_RESET;
      state.irq        <= 1'b0;
      state.bridgeOn   <= 1'b1;
      state.lowSingle  <= 1'b0;
      state.highSingle <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flops
  assign wb_ack_o         = state.ack;
  assign wb_dat_o         = state.rdata;
  assign bridgeModeActive = state.bridgeOn;
  assign lowQuadSingle    = state.lowSingle;
  assign highQuadSingle   = state.highSingle;
  assign irq              = state.irq;

endmodule

`default_nettype wire

//--- tb/psd_diag_regs_properties.sv
/* checker: bus timing, mode outputs and field contents of the bank.
   assumes a classic master that holds its request until ack. */
`timescale 1ns/1ps
`default_nettype none
module psd_diag_regs_properties #(
  parameter int AW = 8
) (
  input wire logic                             ref_clk,
  input wire logic                             rst,
  input wire logic                             wb_cyc_i,
  input wire logic                             wb_stb_i,
  input wire logic                             wb_we_i,
  input wire logic [AW-1:0]                    wb_adr_i,
  input wire logic [3:0]                       wb_sel_i,
  input wire logic [31:0]                      wb_dat_i,
  input wire logic [31:0]                      wb_dat_o,
  input wire logic                             wb_ack_o,
  input wire logic [2*psd_pkg::NUM_STAGES-1:0] stageFaultCode,
  input wire logic [7:0]                       bridgeOneFaultCode,
  input wire logic [7:0]                       bridgeTwoFaultCode,
  input wire logic                             watchdogAlarmPin,
  input wire logic                             bridgeModeActive,
  input wire logic                             lowQuadSingle,
  input wire logic                             highQuadSingle,
  input wire logic                             irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // read answers by register; the address is still held at ack
  logic rdA;
  logic rdC;
  logic rdE;
  logic rdX;
  assign rdX = wb_ack_o && !wb_we_i && !wb_adr_i[7];
  assign rdA = rdX && wb_adr_i[6:2] == psd_pkg::IDX_GROUP_A;
  assign rdC = rdX && wb_adr_i[6:2] == psd_pkg::IDX_GROUP_C;
  assign rdE = rdX && wb_adr_i[6:2] == psd_pkg::IDX_GROUP_E;
  ////////////////////////////////////////////////////////////
  // handshake: ack one cycle after the request, one cycle long
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7] |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  // mode outputs stay consistent with each other
  a_mode_pair: assert property (lowQuadSingle == !bridgeModeActive)
    else $error("single and bridge mode disagree");
  a_lb_priority: assert property (highQuadSingle |-> !bridgeModeActive && lowQuadSingle)
    else $error("low battery did not force single stages");
  // field contents
  a_group_e_ones: assert property (rdE |-> wb_dat_o[7:4] == 4'hf)
    else $error("group e upper bits not ones");
  a_watchdog_live: assert property (
    rdC |-> wb_dat_o[3] == $past(watchdogAlarmPin) && !wb_dat_o[2])
    else $error("watchdog bit not live level");
  a_fault_capture: assert property (
    rdA && !$past(rst, 2) && $past(stageFaultCode[1:0], 2) != 2'h3
    |-> wb_dat_o[1:0] == $past(stageFaultCode[1:0], 2))
    else $error("stage one fault not reported");
  c_fault_read: cover property (rdA && wb_dat_o[1:0] != 2'h3);
  c_low_batt: cover property (highQuadSingle);
  c_irq: cover property (irq);
endmodule

bind psd_diag_regs psd_diag_regs_properties #(.AW(AW)) u_props (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stageFaultCode(stageFaultCode),
  .bridgeOneFaultCode(bridgeOneFaultCode), .bridgeTwoFaultCode(bridgeTwoFaultCode),
  .watchdogAlarmPin(watchdogAlarmPin), .bridgeModeActive(bridgeModeActive),
  .lowQuadSingle(lowQuadSingle), .highQuadSingle(highQuadSingle), .irq(irq)
);
`default_nettype wire

//--- tb/psd_wb_host.sv
/* host model: classic wishbone master, one transfer at a time.
   assumes the bench calls xfer from a single process. */
`timescale 1ns/1ps
`default_nettype none
module psd_wb_host (
  input  wire logic        ref_clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output var logic         cyc,
  output var logic         stb,
  output var logic         we,
  output var logic [7:0]   adr,
  output var logic [3:0]   sel,
  output var logic [31:0]  wdat,
  output var logic         hung
);
  // idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    hung = 1'b0;
  end
  // request held until the edge that samples ack; bounded wait flags a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] m, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= m;
    wdat <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    hung <= (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    wdat <= ~d; // stale data never looks valid
  endtask
endmodule
`default_nettype wire

//--- tb/power_stage_diag_regs_bench.sv
/* bench: random stage faults, bridge codes, modes, irq, bus corners.
   assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module power_stage_diag_regs_bench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc, stb, we, ack, hung, brMode, lowQ, highQ, irq;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, v;
  logic [47:0] code = '1;
  logic [7:0]  br1 = 8'hff;
  logic [7:0]  br2 = 8'h5a;
  logic        wd = 1'b0;
  logic [4:0]  ix;
  int          sh, s, err_total = 0, num_checks = 0;
  logic [7:0]  brc [6] = '{8'h01, 8'h05, 8'h04, 8'h02, 8'h03, 8'h07};

  // 40 mhz clock
  always #12.5 ref_clk = ~ref_clk;

  psd_diag_regs u_dut (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .stageFaultCode(code), .bridgeOneFaultCode(br1), .bridgeTwoFaultCode(br2),
    .watchdogAlarmPin(wd), .bridgeModeActive(brMode), .lowQuadSingle(lowQ),
    .highQuadSingle(highQ), .irq(irq)
  );
  psd_wb_host u_host (
    .ref_clk(ref_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .wdat(wdat), .hung(hung)
  );
  ////////////////////////////////////////////////////////////
  // field position of a stage: register index and bit offset
  function automatic void loc(input int t, output logic [4:0] i, output int b);
    if (t <= 4) i = psd_pkg::IDX_GROUP_A;
    else if (t <= 8) i = psd_pkg::IDX_GROUP_B;
    else if (t <= 14) i = psd_pkg::IDX_GROUP_C;
    else if (t <= 18) i = psd_pkg::IDX_GROUP_D;
    else if (t <= 20) i = psd_pkg::IDX_GROUP_E;
    else i = psd_pkg::IDX_BRIDGE1;
    b = (t == 9) ? 0 : 2 * ((t >= 13 && t <= 20) ? (t + 1) % 4 : (t - 1) % 4);
  endfunction
  // healthy reading, live watchdog level included
  function automatic logic [31:0] base(input logic [4:0] i);
    return (i == psd_pkg::IDX_GROUP_C) ? {24'h0, 4'hf, wd, 3'h3} : 32'h0000_00ff;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(input logic [4:0] i, input logic [31:0] exp);
    u_host.xfer(1'b0, {1'b0, i, 2'b00}, 32'h0, 4'hf, v);
    check(v, exp);
  endtask
  task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic [3:0] m);
    u_host.xfer(1'b1, {1'b0, i, 2'b00}, d, m, v);
  endtask
  // one-cycle fault, the read that reports it, then the read after the clear
  task automatic fault(input int t, input logic [1:0] c);
    @(posedge ref_clk);
    code[2*t-2 +: 2] <= c;
    @(posedge ref_clk);
    code <= '1;
    loc(t, ix, sh);
    rd(ix, base(ix) & ~(32'h3 << sh) | ({30'h0, c} << sh));
    rd(ix, base(ix));
  endtask
  // a hung bus ends the run
  always @(posedge ref_clk) begin
    if (hung === 1'b1) begin
      err_total++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    s = $urandom(61);
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check(32'(brMode), 32'h1);
    rd(psd_pkg::IDX_STEP_CFG, 32'h0000_0001);
    rd(psd_pkg::IDX_GROUP_E, 32'h0000_00ff);
    rd(psd_pkg::IDX_GROUP_C, 32'h0000_00f3);
    rd(psd_pkg::IDX_BRIDGE1, 32'h0000_00ff);
    rd(psd_pkg::IDX_BRIDGE2, 32'h0000_005a);
    rd(5'h00, 32'h0000_0000);
    u_host.xfer(1'b0, 8'h80, 32'h0, 4'hf, v);
    check(v, 32'h0000_0000);
    // read-only register ignores a write
    wr(psd_pkg::IDX_GROUP_A, 32'h0, 4'hf);
    rd(psd_pkg::IDX_GROUP_A, 32'h0000_00ff);
    fault(1, 2'h0);
    fault(8, 2'h1);
    fault(18, 2'h2);
    fault(20, 2'h2);
    repeat (40) begin
      s = $urandom_range(0, 16);
      fault(s < 9 ? s + 1 : s + 4, 2'($urandom_range(0, 2)));
    end
    // watchdog level shows live and survives reads
    @(posedge ref_clk);
    wd <= 1'b1;
    @(posedge ref_clk);
    rd(psd_pkg::IDX_GROUP_C, 32'h0000_00fb);
    rd(psd_pkg::IDX_GROUP_C, 32'h0000_00fb);
    fault(14, 2'h1);
    wd <= 1'b0;
    // fault still present during the clearing read is kept
    @(posedge ref_clk);
    code[1:0] <= psd_pkg::CODE_OPEN_LOAD;
    @(posedge ref_clk);
    rd(psd_pkg::IDX_GROUP_A, 32'h0000_00fd);
    code <= '1;
    rd(psd_pkg::IDX_GROUP_A, 32'h0000_00fd);
    rd(psd_pkg::IDX_GROUP_A, 32'h0000_00ff);
    foreach (brc[i]) begin
      @(posedge ref_clk);
      br1 <= brc[i];
      @(posedge ref_clk);
      br1 <= 8'hff;
      rd(psd_pkg::IDX_BRIDGE1, {24'h0, brc[i]});
      rd(psd_pkg::IDX_BRIDGE1, 32'h0000_00ff);
    end
    // byte lane 0 off: write ignored
    wr(psd_pkg::IDX_STEP_CFG, 32'h0, 4'he);
    check(32'(brMode), 32'h1);
    wr(psd_pkg::IDX_STEP_CFG, 32'h0, 4'h1);
    check(32'(lowQ), 32'h1);
    for (int k = 21; k <= 24; k++) fault(k, 2'($urandom_range(0, 2)));
    wr(psd_pkg::IDX_STEP_CFG, 32'h1, 4'h1);
    wr(psd_pkg::IDX_LB_CTRL, 32'h2, 4'h1);
    check(32'(brMode), 32'h0);
    check(32'(highQ), 32'h1);
    wr(psd_pkg::IDX_LB_CTRL, 32'h0, 4'h1);
    check(32'(brMode), 32'h1);
    // unmasked event raises irq, status read clears it; masked event stays quiet
    // every group has seen a fault by now, so the status starts full
    rd(psd_pkg::IDX_IRQ_STAT, 32'h0000_003f);
    wr(psd_pkg::IDX_IRQ_MASK, 32'h1, 4'h1);
    @(posedge ref_clk);
    code[3:2] <= 2'h0;
    @(posedge ref_clk);
    code <= '1;
    @(posedge ref_clk);
    check(32'(irq), 32'h1);
    rd(psd_pkg::IDX_IRQ_STAT, 32'h0000_0001);
    @(posedge ref_clk);
    check(32'(irq), 32'h0);
    rd(psd_pkg::IDX_GROUP_A, 32'h0000_00f3);
    wr(psd_pkg::IDX_IRQ_MASK, 32'h0, 4'h1);
    fault(5, 2'h2);
    check(32'(irq), 32'h0);
    rd(psd_pkg::IDX_IRQ_STAT, 32'h0000_0002);
    stop_test();
  end
endmodule
`default_nettype wire
